// ### hw/seb_serial_eeprom_bus_slave.sv
// two-wire serial memory slave with 512-byte array and key register
// assumes scl and sda come from outside; open-drain sda, pull-up outside
`timescale 1ns/100ps
`default_nettype none
module seb_serial_eeprom_bus_slave #(
  parameter int WRITE_CYCLE = seb_pkg::WRITE_CYCLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic write_busy
);
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, start_det, stop_det;
  seb_pkg::seb_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic ack_drive;
  logic [15:0] mem_addr;
  logic [seb_pkg::MEM_AW-1:0] cur_addr;
  logic [7:0] mem [seb_pkg::MEM_BYTES];
  logic [7:0] page_buf [seb_pkg::PAGE_BYTES];
  logic [seb_pkg::PAGE_BYTES-1:0] page_valid;
  logic [seb_pkg::MEM_AW-1:0] page_base;
  logic [7:0] key;
  logic [2:0] slave_code;
  logic code_pending;
  logic [31:0] wc_cnt;
  logic do_commit;
  logic wrote_data;

  // two-stage synchronisers on the bus pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // byte framing state machine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= seb_pkg::SEB_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ack_drive <= 1'b0;
      mem_addr <= 16'h0000;
      wrote_data <= 1'b0;
    end else if (start_det) begin
      state <= seb_pkg::SEB_DEVADDR;
      bitcnt <= 4'h0;
      ack_drive <= 1'b0;
      wrote_data <= 1'b0;
    end else if (stop_det) begin
      state <= seb_pkg::SEB_IDLE;
      ack_drive <= 1'b0;
    end else if (scl_rise && state != seb_pkg::SEB_IDLE && state != seb_pkg::SEB_PARK) begin
      if (bitcnt <= seb_pkg::BIT_LAST) begin
        shreg <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 4'h1;
      end else begin
        bitcnt <= 4'h0;
        if (state == seb_pkg::SEB_RACK) begin
          state <= sda_s ? seb_pkg::SEB_PARK : seb_pkg::SEB_RDATA;
        end
      end
    end else if (scl_fall && state != seb_pkg::SEB_IDLE && state != seb_pkg::SEB_PARK) begin
      if (bitcnt == seb_pkg::BIT_ACK && !ack_drive) begin
        case (state)
          seb_pkg::SEB_DEVADDR: begin
            if (shreg[7:4] != seb_pkg::DEVICE_TYPE || shreg[3:1] != slave_code) begin
              state <= seb_pkg::SEB_IDLE;
            end else if (shreg[0]) begin
              state <= seb_pkg::SEB_RDATA;
              ack_drive <= 1'b1;
            end else if (write_busy) begin
              state <= seb_pkg::SEB_IDLE;
            end else begin
              state <= seb_pkg::SEB_ADDRHI;
              ack_drive <= 1'b1;
            end
          end
          seb_pkg::SEB_ADDRHI: begin
            mem_addr[15:8] <= shreg;
            state <= seb_pkg::SEB_ADDRLO;
            ack_drive <= 1'b1;
          end
          seb_pkg::SEB_ADDRLO: begin
            mem_addr[7:0] <= shreg;
            state <= seb_pkg::SEB_WDATA;
            ack_drive <= 1'b1;
          end
          seb_pkg::SEB_WDATA: begin
            wrote_data <= 1'b1;
            ack_drive <= 1'b1;
          end
          seb_pkg::SEB_RDATA: begin
            state <= seb_pkg::SEB_RACK;
          end
          default: begin
          end
        endcase
      end else if (ack_drive) begin
        ack_drive <= 1'b0;
      end
    end
  end

  // read shift out on falling clock, released outside data bits
  logic tx_active;
  logic ack_go;
  assign tx_active = state == seb_pkg::SEB_RDATA && bitcnt <= seb_pkg::BIT_LAST;
  // acknowledge decided at the fall that ends the eighth bit,
  // so the low level is on the line for the whole ninth clock
  // a refused address or a write while busy simply stays released
  assign ack_go = scl_fall && bitcnt == seb_pkg::BIT_ACK && !ack_drive
                  && (state == seb_pkg::SEB_ADDRHI || state == seb_pkg::SEB_ADDRLO || state == seb_pkg::SEB_WDATA
                      || (state == seb_pkg::SEB_DEVADDR && shreg[7:4] == seb_pkg::DEVICE_TYPE
                          && shreg[3:1] == slave_code && (shreg[0] || !write_busy)));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
      txreg <= 8'h00;
    end else if (start_det || stop_det || state == seb_pkg::SEB_PARK || state == seb_pkg::SEB_IDLE) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b1;
    end else if (ack_go) begin
      sda_oe <= 1'b1;
      sda_out <= 1'b0;
      txreg <= mem[cur_addr];
    end else if (scl_fall && tx_active) begin
      sda_oe <= ~txreg[7];
      sda_out <= txreg[7];
      txreg <= {txreg[6:0], 1'b0};
    end else if (scl_fall) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b1;
    end else if (state == seb_pkg::SEB_RACK && scl_rise && !sda_s) begin
      txreg <= mem[cur_addr];
    end
  end

  // address counter and page gather
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_addr <= '0;
      page_valid <= '0;
      page_base <= '0;
      code_pending <= 1'b0;
    end else if (scl_fall && bitcnt == seb_pkg::BIT_ACK && !ack_drive) begin
      if (state == seb_pkg::SEB_ADDRLO) begin
        cur_addr <= {mem_addr[8], shreg};
        page_base <= {mem_addr[8], shreg};
        page_valid <= '0;
        code_pending <= 1'b0;
      end else if (state == seb_pkg::SEB_WDATA) begin
        page_buf[cur_addr[seb_pkg::PAGE_AW-1:0]] <= shreg;
        page_valid[cur_addr[seb_pkg::PAGE_AW-1:0]] <= 1'b1;
        cur_addr <= {cur_addr[seb_pkg::MEM_AW-1:seb_pkg::PAGE_AW],
                     cur_addr[seb_pkg::PAGE_AW-1:0] + 3'h1};
        code_pending <= mem_addr == seb_pkg::SLAVE_CODE_LOC && !wrote_data
                        && key == seb_pkg::UNLOCK_VALUE && shreg[7:3] == 5'h00;
      end else if (state == seb_pkg::SEB_RDATA) begin
        cur_addr <= cur_addr + 9'h001;
      end
    end else if (do_commit) begin
      page_valid <= '0;
      code_pending <= 1'b0;
    end
  end

  // timed write cycle after stop in a write
  assign do_commit = stop_det && state == seb_pkg::SEB_WDATA && wrote_data && !write_busy;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wc_cnt <= 32'h0;
      write_busy <= 1'b0;
    end else if (do_commit) begin
      wc_cnt <= WRITE_CYCLE - 1;
      write_busy <= 1'b1;
    end else if (write_busy) begin
      if (wc_cnt == 32'h0) begin
        write_busy <= 1'b0;
      end else begin
        wc_cnt <= wc_cnt - 32'h1;
      end
    end
  end

  // array commit at start of the write cycle
  // one process owns the whole array
  always_ff @(posedge clk_sys) begin
    for (int pi = 0; pi < seb_pkg::PAGE_BYTES; pi++) begin
      if (do_commit && page_valid[pi] && mem_addr[15:9] == 7'h00) begin
        mem[{page_base[seb_pkg::MEM_AW-1:seb_pkg::PAGE_AW], 3'(pi)}] <= page_buf[pi];
      end
    end
  end

  // slave code store
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slave_code <= seb_pkg::SLAVE_CODE_RESET;
    end else if (do_commit && code_pending) begin
      slave_code <= page_buf[seb_pkg::SLAVE_CODE_LOC[2:0]][2:0];
    end
  end

  // host register port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key <= seb_pkg::KEY_RESET;
    end else if (reg_write && reg_addr == seb_pkg::REG_KEY) begin
      key <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        seb_pkg::REG_KEY: reg_rdata <= key;
        seb_pkg::REG_STATUS: reg_rdata <= {4'h0, write_busy, slave_code};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  property p_key_reset;
    @(posedge clk_sys) $fell(rst) |-> key == seb_pkg::KEY_RESET;
  endproperty
  a_key_reset: assert property (p_key_reset) else $error("key not all ones after reset");

  property p_released_idle;
    @(posedge clk_sys) disable iff (rst)
      state == seb_pkg::SEB_IDLE && $past(state) == seb_pkg::SEB_IDLE |-> !sda_oe;
  endproperty
  a_released_idle: assert property (p_released_idle) else $error("data driven in standby");

  property p_drive_on_fall;
    @(posedge clk_sys) disable iff (rst) $rose(sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive began off a clock fall");

  property p_stop_idle;
    @(posedge clk_sys) disable iff (rst) stop_det |=> state == seb_pkg::SEB_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not reach standby");

  property p_start_addr;
    @(posedge clk_sys) disable iff (rst) start_det |=> state == seb_pkg::SEB_DEVADDR && bitcnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not detected");

  property p_commit_busy;
    @(posedge clk_sys) disable iff (rst) do_commit |=> write_busy && wc_cnt == WRITE_CYCLE - 1;
  endproperty
  a_commit_busy: assert property (p_commit_busy) else $error("write cycle did not start");

  property p_busy_ends;
    @(posedge clk_sys) disable iff (rst) write_busy && wc_cnt == 32'h0 |=> !write_busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("write cycle overran");

  property p_busy_nack;
    @(posedge clk_sys) disable iff (rst)
      write_busy && state == seb_pkg::SEB_DEVADDR && scl_fall && bitcnt == seb_pkg::BIT_ACK && !shreg[0] && !ack_drive
      |=> state == seb_pkg::SEB_IDLE && !ack_drive;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acknowledged during write cycle");

  property p_park_release;
    @(posedge clk_sys) disable iff (rst) state == seb_pkg::SEB_PARK |=> !sda_oe;
  endproperty
  a_park_release: assert property (p_park_release) else $error("drove after missing acknowledge");

  c_write_cycle: cover property (@(posedge clk_sys) disable iff (rst) do_commit);
  c_read_next: cover property (@(posedge clk_sys) disable iff (rst)
    state == seb_pkg::SEB_RACK ##1 state == seb_pkg::SEB_RDATA);
  c_park: cover property (@(posedge clk_sys) disable iff (rst) state == seb_pkg::SEB_PARK);
  c_code_change: cover property (@(posedge clk_sys) disable iff (rst) do_commit && code_pending);
endmodule : seb_serial_eeprom_bus_slave
`default_nettype wire

// ### hw/seb_pkg.sv
// constants for the serial memory bus slave
// assumes a 100 MHz system clock and a host-side register port
package seb_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLE_MS = 10;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int MEM_BYTES = 512;
  localparam int MEM_AW = 9;
  localparam int PAGE_BYTES = 8;
  localparam int PAGE_AW = 3;
  localparam logic [3:0] DEVICE_TYPE = 4'hA;
  localparam logic [7:0] UNLOCK_VALUE = 8'h5F;
  localparam logic [7:0] KEY_RESET = 8'hFF;
  localparam logic [15:0] SLAVE_CODE_LOC = 16'hFF09;
  localparam logic [2:0] SLAVE_CODE_RESET = 3'h0;
  localparam logic [3:0] REG_KEY = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [2:0] {
    SEB_IDLE = 3'b000,
    SEB_DEVADDR = 3'b001,
    SEB_ADDRHI = 3'b011,
    SEB_ADDRLO = 3'b010,
    SEB_WDATA = 3'b110,
    SEB_RDATA = 3'b111,
    SEB_RACK = 3'b101,
    SEB_PARK = 3'b100
  } seb_state_t;
endpackage : seb_pkg

// ### verification/seb_bus_master_model.sv
// two-wire bus master model: drives scl and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
`default_nettype none
module seb_bus_master_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic m_oe
);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    m_oe <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'b0;
  endtask : bit_io
  task automatic start_c();
    m_oe <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    m_oe <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start_c
  task automatic stop_c();
    m_oe <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    m_oe <= 1'b0;
    tick(4);
  endtask : stop_c
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask : wr_byte
  task automatic rd_byte(input logic a, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(a, r);
  endtask : rd_byte
endmodule : seb_bus_master_model
`default_nettype wire

// ### verification/seb_serial_eeprom_bus_slave_tb.sv
// bench for the serial memory slave: register port and serial traffic
// assumes the master model and a pulled-up data wire
`timescale 1ns/100ps
`default_nettype none
module seb_serial_eeprom_bus_slave_tb;
  localparam int WC = 400;
  logic clk_sys, rst, scl, m_oe, sda_out, sda_oe, reg_write, reg_read, write_busy, ack;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  wire sda;
  int fails, tests_run, i;
  assign sda = ~(m_oe | sda_oe);
  seb_serial_eeprom_bus_slave #(.WRITE_CYCLE(WC)) i_dut (.clk_sys(clk_sys), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .write_busy(write_busy));
  seb_bus_master_model i_mst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .m_oe(m_oe));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("Tests run %0d, errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: byte got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: bit got %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_rd
  task automatic send(input logic [7:0] b, input logic e);
    i_mst.wr_byte(b, ack);
    chk1(ack, e);
  endtask : send
  task automatic set_addr(input logic [7:0] dv, input logic [15:0] a);
    i_mst.start_c();
    send(dv, 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
  endtask : set_addr
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < WC + 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk1(write_busy, 1'b0);
  endtask : wait_idle
  initial begin
    #300000;
    fails++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk1(sda_oe, 1'b0);
    chk1(sda_out, 1'b1);
    reg_rd(4'h0, d);
    chk8(d, seb_pkg::KEY_RESET);
    reg_rd(4'h1, d);
    chk8(d, 8'h00);
    reg_wr(4'h0, 8'h3C);
    reg_rd(4'h0, d);
    chk8(d, 8'h3C);
    reg_rd(4'h7, d);
    chk8(d, 8'h00);
    set_addr(8'hA0, 16'h0012);
    send(8'hA5, 1'b0);
    i_mst.stop_c();
    i_mst.tick(4);
    chk1(write_busy, 1'b1);
    i_mst.start_c();
    send(8'hA0, 1'b1);
    i_mst.stop_c();
    wait_idle();
    set_addr(8'hA0, 16'h0106);
    for (i = 0; i < 9; i++) send(8'h10 + i[7:0], 1'b0);
    i_mst.stop_c();
    wait_idle();
    set_addr(8'hA0, 16'h0100);
    i_mst.start_c();
    send(8'hA1, 1'b0);
    for (i = 0; i < 8; i++) begin
      i_mst.rd_byte(i == 7, d);
      chk8(d, (i == 7) ? 8'h11 : 8'h12 + i[7:0]);
    end
    i_mst.rd_byte(1'b1, d);
    chk8(d, 8'hFF);
    i_mst.stop_c();
    chk1(sda_oe, 1'b0);
    i_mst.start_c();
    send(8'hB0, 1'b1);
    i_mst.start_c();
    send(8'hA2, 1'b1);
    i_mst.stop_c();
    reg_wr(4'h0, seb_pkg::UNLOCK_VALUE);
    set_addr(8'hA0, seb_pkg::SLAVE_CODE_LOC);
    send(8'h03, 1'b0);
    i_mst.stop_c();
    wait_idle();
    reg_rd(4'h1, d);
    chk8(d, 8'h03);
    i_mst.start_c();
    send(8'hA0, 1'b1);
    set_addr(8'hA6, 16'h0012);
    i_mst.start_c();
    send(8'hA7, 1'b0);
    i_mst.rd_byte(1'b1, d);
    chk8(d, 8'hA5);
    i_mst.stop_c();
    stop_test();
  end
endmodule : seb_serial_eeprom_bus_slave_tb
`default_nettype wire
